//--- txpcr_top.sv
// Transmit configuration register bank with serial register port
//
// Contract
// - Pin1 bit 7 sets drive strength
// - Bit 6 inverts each pin's output
// - Pin1 select six bits, resets three-state
// - Pin0 select resets to crystal/192 clock
// - Compare FIFO fill against threshold bytes
// - Frame marker high/low bytes, reset D391
// - Source 00 takes data from FIFO
// - Source 01 synchronous serial via pin0
// - Source 10 sends PN9 test data
// - Source 11 asynchronous serial via pin0
// - Bit 2 enables checksum, resets one
// - Length mode 00 uses fixed length
// - Mode 01 first FIFO byte is length
// - Mode 10 unlimited; 11 reserved
// - Carrier = base + slot times spacing
// - Registers read/written single or burst
`timescale 1ns/100ps
module txpcr_top (
  // Clock and reset
  input  wire logic        I_REF_CLK,
  input  wire logic        I_RESETN,
  // Serial register port
  input  wire logic        I_SPI_SCLK,
  input  wire logic        I_SPI_CSN,
  input  wire logic        I_SPI_SI,
  output      logic        O_SPI_SO,
  output      logic        O_SPI_SO_OE,
  // General-purpose pins
  input  wire logic        I_GP_PIN0,
  output      logic        O_GP_PIN0,
  output      logic        O_GP_PIN0_OE,
  output      logic        O_GP_PIN1,
  output      logic        O_GP_PIN1_OE,
  output      logic        O_DRIVE_HIGH,
  input  wire logic        I_PIN0_SIGNAL,
  input  wire logic        I_PIN1_SIGNAL,
  output      logic [5:0]  O_PIN0_SELECT,
  output      logic [5:0]  O_PIN1_SELECT,
  // Transmit FIFO side
  input  wire logic [6:0]  I_TX_BYTES,
  input  wire logic        I_FIFO_WR,
  input  wire logic [7:0]  I_FIFO_WDATA,
  input  wire logic        I_FRAME_DONE,
  input  wire logic        I_FIFO_BIT,
  input  wire logic        I_BIT_TICK,
  output      logic        O_THR_EXCEEDED,
  output      logic        O_TX_BIT,
  output      logic [1:0]  O_TX_SOURCE,
  // Frame settings
  output      logic [15:0] O_FRAME_MARKER,
  output      logic [7:0]  O_FRAME_LEN,
  output      logic        O_LEN_FROM_FIFO,
  output      logic        O_LEN_UNLIMITED,
  output      logic        O_CRC_ENABLE,
  // Carrier frequency
  input  wire logic [23:0] I_BASE_FREQ,
  input  wire logic [15:0] I_CARRIER_SLOT_VALUE_SPACING,
  output      logic [23:0] O_CARRIER_WORD
);

  typedef enum logic [1:0] {
    SPI_IDLE   = 2'b00,
    SPI_HEADER = 2'b01,
    SPI_DATA   = 2'b10
  } txpcr_spi_e;

  logic                 rst_meta_n;
  logic                 rst_n;
  logic [3:0]           pin_level;
  logic                 csn;
  logic                 sclk;
  logic                 si;
  logic                 pin0_in;
  logic                 sclk_q;
  logic                 sclk_rise;
  logic                 sclk_fall;
  txpcr_spi_e           spi_state;
  logic [2:0]           bit_cnt;
  logic [7:0]           rx_shift;
  logic [7:0]           rx_byte;
  logic                 byte_done;
  logic                 acc_read;
  logic                 acc_burst;
  logic [5:0]           acc_addr;
  logic [5:0]           next_addr;
  logic [7:0]           tx_shift;
  logic                 wr_en;
  txpcr_pkg::txpcr_regs_s regs;
  txpcr_pkg::txpcr_src_e  src;
  txpcr_pkg::txpcr_len_e  len_mode;
  logic [6:0]           thr_bytes;
  logic [6:0]           xdiv_cnt;
  logic                 xdiv_clk;
  logic [8:0]           pn9;
  logic                 sync_bit;
  logic                 len_pending;
  logic [7:0]           fifo_len;
  logic [5:0]           sel0;
  logic [5:0]           sel1;
  logic                 serial_in;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisation

  always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  txpcr_pin_sync #(
    .W       (4),
    .RST_VAL (4'h8)
  ) u_pin_sync (
    .i_clk   (I_REF_CLK),
    .i_rst_n (rst_n),
    .i_async ({I_SPI_CSN, I_SPI_SCLK, I_SPI_SI, I_GP_PIN0}),
    .o_level (pin_level)
  );

  assign csn       = pin_level[3];
  assign sclk      = pin_level[2];
  assign si        = pin_level[1];
  assign pin0_in   = pin_level[0];
  assign sclk_rise = sclk & ~sclk_q;
  assign sclk_fall = ~sclk & sclk_q;
  assign rx_byte   = {rx_shift[6:0], si};
  assign byte_done = sclk_rise && (bit_cnt == txpcr_pkg::LAST_BIT);
  assign next_addr = acc_addr + 6'h01;

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial access: header byte, then one data byte or a burst

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      spi_state <= SPI_IDLE;
      bit_cnt   <= 3'h0;
      rx_shift  <= 8'h00;
      acc_read  <= 1'b0;
      acc_burst <= 1'b0;
      acc_addr  <= 6'h00;
    end else if (csn) begin
      spi_state <= SPI_IDLE;
      bit_cnt   <= 3'h0;
    end else begin
      unique case (spi_state)
        SPI_IDLE: begin
          spi_state <= SPI_HEADER;
          bit_cnt   <= 3'h0;
        end
        SPI_HEADER, SPI_DATA: begin
          if (sclk_rise) begin
            rx_shift <= rx_byte;
            bit_cnt  <= bit_cnt + 3'h1;
          end
          if (byte_done && spi_state == SPI_HEADER) begin
            acc_read  <= rx_byte[txpcr_pkg::HDR_READ_BIT];
            acc_burst <= rx_byte[txpcr_pkg::HDR_BURST_BIT];
            acc_addr  <= rx_byte[5:0];
            spi_state <= SPI_DATA;
          end else if (byte_done) begin
            if (acc_burst) begin
              acc_addr <= next_addr;
            end else begin
              spi_state <= SPI_HEADER;
            end
          end
        end
        default: begin
          spi_state <= SPI_IDLE;
        end
      endcase
    end
  end

  function automatic logic [7:0] reg_read(input logic [5:0] a,
                                          input txpcr_pkg::txpcr_regs_s r);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      txpcr_pkg::ADDR_PIN1:    d = r.pin1;
      txpcr_pkg::ADDR_PIN0:    d = r.pin0;
      txpcr_pkg::ADDR_THR:     d = r.thr;
      txpcr_pkg::ADDR_MARK_HI: d = r.mark_hi;
      txpcr_pkg::ADDR_MARK_LO: d = r.mark_lo;
      txpcr_pkg::ADDR_FIXLEN:  d = r.fixlen;
      txpcr_pkg::ADDR_AUTO:    d = r.auto_ctl;
      txpcr_pkg::ADDR_SLOT:    d = r.slot;
      default:                 d = 8'h00;
    endcase
    return d;
  endfunction : reg_read

  // Read data is loaded at the byte boundary and shifted out on falling clock edges
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift    <= txpcr_pkg::STATUS_BYTE;
      O_SPI_SO    <= 1'b0;
      O_SPI_SO_OE <= 1'b0;
    end else if (csn || spi_state == SPI_IDLE) begin
      tx_shift    <= txpcr_pkg::STATUS_BYTE;
      O_SPI_SO    <= 1'b0;
      O_SPI_SO_OE <= ~csn;
    end else begin
      O_SPI_SO_OE <= 1'b1;
      if (byte_done) begin
        if (spi_state == SPI_HEADER && rx_byte[txpcr_pkg::HDR_READ_BIT]) begin
          tx_shift <= reg_read(rx_byte[5:0], regs);
        end else if (spi_state == SPI_DATA && acc_read && acc_burst) begin
          tx_shift <= reg_read(next_addr, regs);
        end else begin
          tx_shift <= txpcr_pkg::STATUS_BYTE;
        end
      end else if (sclk_fall) begin
        O_SPI_SO <= tx_shift[7];
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  assign wr_en = byte_done && !csn && spi_state == SPI_DATA && !acc_read;

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      regs <= txpcr_pkg::RST_REGS;
    end else if (wr_en) begin
      unique case (acc_addr)
        txpcr_pkg::ADDR_PIN1:    regs.pin1    <= rx_byte;
        txpcr_pkg::ADDR_PIN0:    regs.pin0    <= rx_byte;
        txpcr_pkg::ADDR_THR:     regs.thr     <= rx_byte;
        txpcr_pkg::ADDR_MARK_HI: regs.mark_hi <= rx_byte;
        txpcr_pkg::ADDR_MARK_LO: regs.mark_lo <= rx_byte;
        txpcr_pkg::ADDR_FIXLEN:  regs.fixlen  <= rx_byte;
        txpcr_pkg::ADDR_AUTO:    regs.auto_ctl <= rx_byte & txpcr_pkg::AUTO_WR_MASK;
        txpcr_pkg::ADDR_SLOT:    regs.slot    <= rx_byte;
        default:                 regs         <= regs;
      endcase
    end
  end

  assign src       = txpcr_pkg::txpcr_src_e'(
                       regs.auto_ctl[txpcr_pkg::SRC_MSB:txpcr_pkg::SRC_LSB]);
  assign len_mode  = txpcr_pkg::txpcr_len_e'(
                       regs.auto_ctl[txpcr_pkg::LEN_MSB:txpcr_pkg::LEN_LSB]);
  assign sel0      = regs.pin0[txpcr_pkg::SEL_MSB:txpcr_pkg::SEL_LSB];
  assign sel1      = regs.pin1[txpcr_pkg::SEL_MSB:txpcr_pkg::SEL_LSB];
  assign serial_in = (src == txpcr_pkg::SRC_SYNC) || (src == txpcr_pkg::SRC_ASYNC);
  assign thr_bytes = txpcr_pkg::THR_BASE
                   - 7'({regs.thr[txpcr_pkg::THR_MSB:txpcr_pkg::THR_LSB], 2'b00});

  ////////////////////////////////////////////////////////////////////////////
  // Output pins

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      xdiv_cnt <= 7'h00;
      xdiv_clk <= 1'b0;
    end else if (xdiv_cnt == txpcr_pkg::XDIV_HALF_LAST) begin
      xdiv_cnt <= 7'h00;
      xdiv_clk <= ~xdiv_clk;
    end else begin
      xdiv_cnt <= xdiv_cnt + 7'h01;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_GP_PIN0     <= 1'b0;
      O_GP_PIN0_OE  <= 1'b0;
      O_GP_PIN1     <= 1'b0;
      O_GP_PIN1_OE  <= 1'b0;
      O_DRIVE_HIGH  <= 1'b0;
      O_PIN0_SELECT <= 6'h00;
      O_PIN1_SELECT <= 6'h00;
    end else begin
      O_DRIVE_HIGH  <= regs.pin1[txpcr_pkg::DS_BIT];
      O_PIN0_SELECT <= sel0;
      O_PIN1_SELECT <= sel1;
      O_GP_PIN1_OE  <= (sel1 != txpcr_pkg::SEL_TRISTATE);
      O_GP_PIN1     <= ((sel1 == txpcr_pkg::SEL_XTAL_DIV) ? xdiv_clk : I_PIN1_SIGNAL)
                     ^ regs.pin1[txpcr_pkg::INV_BIT];
      // Pin0 turns into the data input in the serial modes
      O_GP_PIN0_OE  <= (sel0 != txpcr_pkg::SEL_TRISTATE) && !serial_in;
      O_GP_PIN0     <= ((sel0 == txpcr_pkg::SEL_XTAL_DIV) ? xdiv_clk : I_PIN0_SIGNAL)
                     ^ regs.pin0[txpcr_pkg::INV_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit data source

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pn9 <= txpcr_pkg::PN9_SEED;
    end else if (src == txpcr_pkg::SRC_PN9 && I_BIT_TICK) begin
      pn9 <= {pn9[0] ^ pn9[txpcr_pkg::PN9_TAP], pn9[8:1]};
    end
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sync_bit <= 1'b0;
    end else if (I_BIT_TICK) begin
      sync_bit <= pin0_in;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_TX_BIT    <= 1'b0;
      O_TX_SOURCE <= 2'b00;
    end else begin
      O_TX_SOURCE <= src;
      unique case (src)
        txpcr_pkg::SRC_FIFO:  O_TX_BIT <= I_FIFO_BIT;
        txpcr_pkg::SRC_SYNC:  O_TX_BIT <= sync_bit;
        txpcr_pkg::SRC_PN9:   O_TX_BIT <= pn9[0];
        txpcr_pkg::SRC_ASYNC: O_TX_BIT <= pin0_in;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_THR_EXCEEDED <= 1'b0;
    end else begin
      O_THR_EXCEEDED <= (I_TX_BYTES >= thr_bytes);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame format

  // A frame end rearms the capture even if a FIFO write lands in the same cycle
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      len_pending <= 1'b1;
      fifo_len    <= 8'h00;
    end else if (I_FRAME_DONE) begin
      len_pending <= 1'b1;
    end else if (I_FIFO_WR && len_pending) begin
      len_pending <= 1'b0;
      fifo_len    <= I_FIFO_WDATA;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_FRAME_MARKER  <= 16'h0000;
      O_FRAME_LEN     <= 8'h00;
      O_LEN_FROM_FIFO <= 1'b0;
      O_LEN_UNLIMITED <= 1'b0;
      O_CRC_ENABLE    <= 1'b0;
      O_CARRIER_WORD  <= 24'h000000;
    end else begin
      O_FRAME_MARKER  <= {regs.mark_hi, regs.mark_lo};
      O_CRC_ENABLE    <= regs.auto_ctl[txpcr_pkg::CRC_BIT];
      O_LEN_FROM_FIFO <= (len_mode == txpcr_pkg::LEN_VARIABLE);
      O_LEN_UNLIMITED <= (len_mode == txpcr_pkg::LEN_UNLIMITED);
      unique case (len_mode)
        txpcr_pkg::LEN_FIXED:    O_FRAME_LEN <= regs.fixlen;
        txpcr_pkg::LEN_VARIABLE: O_FRAME_LEN <= fifo_len;
        default:                 O_FRAME_LEN <= 8'h00;
      endcase
      O_CARRIER_WORD  <= I_BASE_FREQ + 24'(regs.slot) * 24'(I_CARRIER_SLOT_VALUE_SPACING);
    end
  end

endmodule : txpcr_top

//--- txpcr_pkg.sv
// Shared constants, modes and register layout for the transmit configuration bank
package txpcr_pkg;

  // Register offsets on the serial interface
  localparam logic [5:0] ADDR_PIN1      = 6'h01;
  localparam logic [5:0] ADDR_PIN0      = 6'h02;
  localparam logic [5:0] ADDR_THR       = 6'h03;
  localparam logic [5:0] ADDR_MARK_HI   = 6'h04;
  localparam logic [5:0] ADDR_MARK_LO   = 6'h05;
  localparam logic [5:0] ADDR_FIXLEN    = 6'h06;
  localparam logic [5:0] ADDR_AUTO      = 6'h08;
  localparam logic [5:0] ADDR_SLOT      = 6'h0A;

  // Reset values
  localparam logic [7:0] RST_PIN1       = 8'h2E;
  localparam logic [7:0] RST_PIN0       = 8'h3F;
  localparam logic [7:0] RST_THR        = 8'h07;
  localparam logic [7:0] RST_MARK_HI    = 8'hD3;
  localparam logic [7:0] RST_MARK_LO    = 8'h91;
  localparam logic [7:0] RST_FIXLEN     = 8'hFF;
  localparam logic [7:0] RST_AUTO       = 8'h45;
  localparam logic [7:0] RST_SLOT       = 8'h00;

  // Field positions
  localparam int         DS_BIT         = 7;
  localparam int         INV_BIT        = 6;
  localparam int         SEL_MSB        = 5;
  localparam int         SEL_LSB        = 0;
  localparam int         THR_MSB        = 3;
  localparam int         THR_LSB        = 0;
  localparam int         SRC_MSB        = 5;
  localparam int         SRC_LSB        = 4;
  localparam int         CRC_BIT        = 2;
  localparam int         LEN_MSB        = 1;
  localparam int         LEN_LSB        = 0;
  localparam logic [7:0] AUTO_WR_MASK   = 8'h77;

  // Signal select codes with a fixed meaning
  localparam logic [5:0] SEL_TRISTATE   = 6'h2E;
  localparam logic [5:0] SEL_XTAL_DIV   = 6'h3F;

  // Serial header layout
  localparam int         HDR_READ_BIT   = 7;
  localparam int         HDR_BURST_BIT  = 6;
  localparam logic [2:0] LAST_BIT       = 3'h7;
  localparam logic [7:0] STATUS_BYTE    = 8'h00;

  // Threshold map: setting n gives THR_BASE - 4n bytes
  localparam logic [6:0] THR_BASE       = 7'h3D;

  // Crystal clock divider on the output pins
  localparam int         XDIV_RATIO     = 192;
  localparam logic [6:0] XDIV_HALF_LAST = 7'(XDIV_RATIO / 2 - 1);

  // Nine-stage pseudo-random generator
  localparam logic [8:0] PN9_SEED       = 9'h1FF;
  localparam int         PN9_TAP        = 5;

  typedef enum logic [1:0] {
    SRC_FIFO  = 2'b00,
    SRC_SYNC  = 2'b01,
    SRC_PN9   = 2'b10,
    SRC_ASYNC = 2'b11
  } txpcr_src_e;

  typedef enum logic [1:0] {
    LEN_FIXED     = 2'b00,
    LEN_VARIABLE  = 2'b01,
    LEN_UNLIMITED = 2'b10,
    LEN_RESERVED  = 2'b11
  } txpcr_len_e;

  typedef struct packed {
    logic [7:0] pin1;
    logic [7:0] pin0;
    logic [7:0] thr;
    logic [7:0] mark_hi;
    logic [7:0] mark_lo;
    logic [7:0] fixlen;
    logic [7:0] auto_ctl;
    logic [7:0] slot;
  } txpcr_regs_s;

  localparam txpcr_regs_s RST_REGS = '{
    pin1: RST_PIN1, pin0: RST_PIN0, thr: RST_THR, mark_hi: RST_MARK_HI,
    mark_lo: RST_MARK_LO, fixlen: RST_FIXLEN, auto_ctl: RST_AUTO, slot: RST_SLOT
  };

endpackage : txpcr_pkg

//--- txpcr_pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module txpcr_pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Pins
  input  wire logic [W-1:0] i_async,
  output      logic [W-1:0] o_level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A bit moves only once the last two stages agree
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= RST_VAL;
    end else begin
      o_level <= (s2 & s3) | (o_level & (s2 ^ s3));
    end
  end

endmodule : txpcr_pin_sync

//--- txpcr_assertions.sv
// Port checker for the transmit configuration bank
`timescale 1ns/100ps
module txpcr_assertions (
  // Clock and reset
  input wire logic        I_REF_CLK,
  input wire logic        I_RESETN,
  // Watched ports
  input wire logic        I_SPI_CSN,
  input wire logic        O_SPI_SO_OE,
  input wire logic        I_GP_PIN0,
  input wire logic        O_GP_PIN0_OE,
  input wire logic        O_GP_PIN1_OE,
  input wire logic [5:0]  O_PIN0_SELECT,
  input wire logic [5:0]  O_PIN1_SELECT,
  input wire logic [6:0]  I_TX_BYTES,
  input wire logic        I_FIFO_BIT,
  input wire logic        O_THR_EXCEEDED,
  input wire logic        O_TX_BIT,
  input wire logic [1:0]  O_TX_SOURCE,
  input wire logic [15:0] O_FRAME_MARKER,
  input wire logic [7:0]  O_FRAME_LEN,
  input wire logic        O_LEN_FROM_FIFO,
  input wire logic        O_LEN_UNLIMITED,
  input wire logic        O_CRC_ENABLE
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);

  // Margin covers the two-stage reset copy plus the output register
  a_reset_fields: assert property ($rose(I_RESETN) |-> ##6 (O_PIN1_SELECT == 6'h2E
    && O_PIN0_SELECT == 6'h3F && O_FRAME_MARKER == 16'hD391 && O_CRC_ENABLE && O_LEN_FROM_FIFO))
    else $error("bank outputs wrong after reset");
  a_pin1_tristate: assert property ((O_PIN1_SELECT == 6'h2E) [*3] |-> !O_GP_PIN1_OE)
    else $error("pin1 driven while three-state selected");
  a_pin0_serial_in: assert property (O_TX_SOURCE[0] [*3] |-> !O_GP_PIN0_OE)
    else $error("pin0 driven while it carries serial input");
  a_thr_full: assert property ((I_TX_BYTES >= 7'h3D) [*2] |-> O_THR_EXCEEDED)
    else $error("threshold not flagged at 61 bytes");
  a_thr_empty: assert property ((I_TX_BYTES == 7'h00) [*2] |-> !O_THR_EXCEEDED)
    else $error("threshold flagged with empty fifo");
  a_fifo_path: assert property ((O_TX_SOURCE == 2'b00 && I_FIFO_BIT) [*3] |-> O_TX_BIT)
    else $error("fifo bit not passed to transmitter");
  // Eight cycles cover the pin synchroniser and the output register
  a_async_path: assert property ((O_TX_SOURCE == 2'b11 && I_GP_PIN0) [*8] |-> O_TX_BIT)
    else $error("pin0 level not passed in asynchronous mode");
  a_len_modes: assert property (!(O_LEN_FROM_FIFO && O_LEN_UNLIMITED))
    else $error("two length modes active together");
  a_unlim_len: assert property (O_LEN_UNLIMITED [*3] |-> O_FRAME_LEN == 8'h00)
    else $error("length reported in unlimited mode");
  a_so_idle: assert property (I_SPI_CSN [*8] |-> !O_SPI_SO_OE)
    else $error("serial output enabled while deselected");

  c_unlim: cover property (O_LEN_UNLIMITED);
  c_pn_one: cover property (O_TX_SOURCE == 2'b10 && O_TX_BIT);
  c_thr_hit: cover property ($rose(O_THR_EXCEEDED));
endmodule : txpcr_assertions

bind txpcr_top txpcr_assertions u_chk (.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN),
  .I_SPI_CSN(I_SPI_CSN), .O_SPI_SO_OE(O_SPI_SO_OE), .I_GP_PIN0(I_GP_PIN0),
  .O_GP_PIN0_OE(O_GP_PIN0_OE), .O_GP_PIN1_OE(O_GP_PIN1_OE), .O_PIN0_SELECT(O_PIN0_SELECT),
  .O_PIN1_SELECT(O_PIN1_SELECT), .I_TX_BYTES(I_TX_BYTES), .I_FIFO_BIT(I_FIFO_BIT),
  .O_THR_EXCEEDED(O_THR_EXCEEDED), .O_TX_BIT(O_TX_BIT), .O_TX_SOURCE(O_TX_SOURCE),
  .O_FRAME_MARKER(O_FRAME_MARKER), .O_FRAME_LEN(O_FRAME_LEN),
  .O_LEN_FROM_FIFO(O_LEN_FROM_FIFO), .O_LEN_UNLIMITED(O_LEN_UNLIMITED),
  .O_CRC_ENABLE(O_CRC_ENABLE));

//--- txpcr_host_model.sv
// Host microcontroller model: serial register master, mode 0, MSB first
`timescale 1ns/100ps
module txpcr_host_model (
  // Clock
  input  wire logic       i_clk,
  // Serial port
  input  wire logic       i_so,
  output      logic       o_sclk,
  output      logic       o_csn,
  output      logic       o_si,
  // Received read bytes
  output      logic       o_rd_valid,
  output      logic [7:0] o_rd_byte
);
  // Start deselected with the clock low
  initial begin
    o_sclk     <= 1'b0;
    o_csn      <= 1'b1;
    o_si       <= 1'b0;
    o_rd_valid <= 1'b0;
    o_rd_byte  <= 8'h00;
  end

  // Phase length above the 6-clock minimum, leaving room for output latency
  localparam int HALF = 10;

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc

  task automatic select(input logic on);
    cyc(12);
    o_csn <= !on;
    if (!on) o_si <= !o_si;  // Released line must not keep a stale bit
    cyc(12);
  endtask : select

  // Clock idles low between frames; data changes only while it is low
  task automatic xfer(input logic [7:0] tx, input logic note);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      o_si <= tx[i];
      cyc(HALF);
      rx[i] = i_so;
      o_sclk <= 1'b1;
      cyc(HALF);
      o_sclk <= 1'b0;
    end
    if (note) begin
      o_rd_byte <= rx;
      o_rd_valid <= 1'b1;
      cyc(1);
      o_rd_valid <= 1'b0;
    end
  endtask : xfer
endmodule : txpcr_host_model

//--- testbench.sv
// Self-checking bench for the transmit configuration bank
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0, rst_n, gp0, sig0, sig1;
  logic        fwr, fdone, fbit, tick, prev;
  logic        sclk, csn, si, so, so_oe, p0, p0_oe, p1, p1_oe, drv, thr_x, txb, lff, lun, crc;
  logic        rdv;
  logic [1:0]  src;
  logic [5:0]  sel0, sel1;
  logic [6:0]  nbytes;
  logic [7:0]  fdata, flen, rdb, fl, mh, ml, d, v, slot;
  logic [15:0] mark, sp;
  logic [23:0] base, cw;
  logic [7:0]  exp_q[$];
  logic        pn[24];
  int          num_errors = 0, checks_done = 0, k;
  localparam logic [7:0] RST_RD[10] = '{8'h2E, 8'h3F, 8'h07, 8'hD3, 8'h91,
                                        8'hFF, 8'h00, 8'h45, 8'h00, 8'h00};

  txpcr_top dut (.I_REF_CLK(clk), .I_RESETN(rst_n), .I_SPI_SCLK(sclk), .I_SPI_CSN(csn),
    .I_SPI_SI(si), .O_SPI_SO(so), .O_SPI_SO_OE(so_oe), .I_GP_PIN0(gp0), .O_GP_PIN0(p0),
    .O_GP_PIN0_OE(p0_oe), .O_GP_PIN1(p1), .O_GP_PIN1_OE(p1_oe), .O_DRIVE_HIGH(drv),
    .I_PIN0_SIGNAL(sig0), .I_PIN1_SIGNAL(sig1), .O_PIN0_SELECT(sel0), .O_PIN1_SELECT(sel1),
    .I_TX_BYTES(nbytes), .I_FIFO_WR(fwr), .I_FIFO_WDATA(fdata), .I_FRAME_DONE(fdone),
    .I_FIFO_BIT(fbit), .I_BIT_TICK(tick), .O_THR_EXCEEDED(thr_x), .O_TX_BIT(txb),
    .O_TX_SOURCE(src), .O_FRAME_MARKER(mark), .O_FRAME_LEN(flen), .O_LEN_FROM_FIFO(lff),
    .O_LEN_UNLIMITED(lun), .O_CRC_ENABLE(crc), .I_BASE_FREQ(base), .I_CARRIER_SLOT_VALUE_SPACING(sp),
    .O_CARRIER_WORD(cw));
  txpcr_host_model host (.i_clk(clk), .i_so(so), .o_sclk(sclk), .o_csn(csn), .o_si(si),
    .o_rd_valid(rdv), .o_rd_byte(rdb));

  always #4 clk = ~clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] dat);
    host.select(1'b1);
    host.xfer({2'b00, a}, 1'b0);
    host.xfer(dat, 1'b0);
    host.select(1'b0);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.select(1'b1);
    host.xfer({2'b10, a}, 1'b0);
    host.xfer(8'h00, 1'b1);
    host.select(1'b0);
  endtask : rd

  task automatic final_report;
    // A read whose answer never came back counts against the run
    if (exp_q.size() != 0) num_errors++;
    $display("TB: %0d checks, %0d mismatches", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Read results come back in request order
  always @(posedge clk) begin
    if (rdv === 1'b1) chk(32'(rdb), 32'(exp_q.pop_front()));
  end

  initial begin
    cyc(40000);
    num_errors++;
    final_report();
  end

  initial begin
    rst_n <= 1'b0;
    {gp0, sig0, sig1, fwr, fdone, fbit, tick, nbytes, fdata} <= 22'h000000;
    {sp, base} <= 40'h0000000000;
    void'($urandom(86));
    cyc(16);
    rst_n <= 1'b1;
    cyc(20);
    chk({sel1, sel0, mark}, {6'h2E, 6'h3F, 16'hD391});
    chk({crc, lff, lun, src}, 5'b11000);
    k = -1;
    @(negedge clk);
    prev = p0;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk);
      if (p0 !== prev && k >= 0) chk(i - k, 96);
      if (p0 !== prev) k = i;
      prev = p0;
    end
    chk(k > 0, 1'b1);
    host.select(1'b1);
    host.xfer(8'hC1, 1'b0);
    foreach (RST_RD[i]) begin
      exp_q.push_back(RST_RD[i]);
      host.xfer(8'h00, 1'b1);
    end
    host.select(1'b0);
    $display("test reset values done");
    wr(txpcr_pkg::ADDR_PIN0, 8'h2E);
    mh = 8'($urandom);
    ml = 8'($urandom);
    fl = 8'($urandom_range(255, 1));
    host.select(1'b1);
    host.xfer(8'h44, 1'b0);
    host.xfer(mh, 1'b0);
    host.xfer(ml, 1'b0);
    host.xfer(fl, 1'b0);
    host.select(1'b0);
    rd(txpcr_pkg::ADDR_MARK_HI, mh);
    rd(txpcr_pkg::ADDR_MARK_LO, ml);
    rd(txpcr_pkg::ADDR_FIXLEN, fl);
    chk(mark, {mh, ml});
    wr(6'h07, 8'hA5);
    rd(6'h07, 8'h00);
    base <= 24'($urandom);
    sp <= 16'($urandom);
    slot = 8'($urandom);
    wr(txpcr_pkg::ADDR_SLOT, slot);
    chk(cw, 24'(base + slot * sp));
    $display("test burst and slot done");
    for (int inv = 0; inv < 2; inv++) begin
      wr(txpcr_pkg::ADDR_PIN1, inv ? 8'hC0 : 8'h00);
      wr(txpcr_pkg::ADDR_PIN0, inv ? 8'h40 : 8'h00);
      for (int s = 0; s < 2; s++) begin
        sig0 <= s[0];
        sig1 <= s[0];
        cyc(3);
        chk({drv, p1_oe, p1, p0_oe, p0}, {inv[0], 1'b1, s[0] ^ inv[0], 1'b1, s[0] ^ inv[0]});
      end
    end
    $display("test pins done");
    for (int n = 0; n < 16; n++) begin
      wr(txpcr_pkg::ADDR_THR, 8'(n));
      nbytes <= 7'(61 - 4 * n);
      cyc(3);
      chk(thr_x, 1'b1);
      nbytes <= 7'(60 - 4 * n);
      cyc(3);
      chk(thr_x, 1'b0);
    end
    $display("test threshold done");
    for (int m = 0; m < 3; m++) begin
      v = {3'b110, 2'b01, m[0], m[1:0]};
      wr(txpcr_pkg::ADDR_AUTO, v);
      rd(txpcr_pkg::ADDR_AUTO, v & 8'h77);
      d = 8'($urandom);
      fdone <= 1'b1;
      cyc(1);
      fdone <= 1'b0;
      fwr <= 1'b1;
      fdata <= d;
      cyc(1);
      fdata <= ~d;
      cyc(1);
      fwr <= 1'b0;
      cyc(3);
      chk({crc, lff, lun, flen}, {m[0], m == 1, m == 2, m == 0 ? fl : (m == 1 ? d : 8'h00)});
    end
    $display("test length modes done");
    for (int s = 0; s < 4; s++) begin
      wr(txpcr_pkg::ADDR_AUTO, 8'h42 | 8'(s << 4));
      chk({src, p0_oe}, {s[1:0], ~s[0]});
      if (s == 2) begin
        for (int j = 0; j < 24; j++) begin
          tick <= 1'b1;
          cyc(1);
          tick <= 1'b0;
          cyc(5);
          pn[j] = txb;
        end
        for (int j = 0; j < 15; j++) chk(pn[j + 9], pn[j] ^ pn[j + 5]);
      end else begin
        for (int b = 0; b < 2; b++) begin
          fbit <= b[0];
          gp0 <= b[0];
          cyc(8);
          tick <= 1'b1;
          cyc(1);
          tick <= 1'b0;
          cyc(8);
          chk(txb, b[0]);
        end
      end
    end
    $display("test data sources done");
    final_report();
  end
endmodule : testbench
